// [rtl/cfs_defs.vh]
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

// Clock and timing
`define CFS_CLK_MHZ        10
`define CFS_BLANK_NS       100
`define CFS_BLANK_CYC      ((`CFS_BLANK_NS * `CFS_CLK_MHZ + 999) / 1000)
`define CFS_SS_STEP_US     1000
`define CFS_SS_STEP_CYC    (`CFS_SS_STEP_US * `CFS_CLK_MHZ)
`define CFS_SS_STEPS       4'h8
`define CFS_SC_LIMIT       3'h7

// Thresholds in degrees C and mV codes, amplifier gain and hysteresis percent
`define CFS_TEMP_TRIP      8'h9B
`define CFS_TEMP_RELEASE   8'h87
`define CFS_ADAPTER_MV     12'h960
`define CFS_CURMON_MV      17'h000FA
`define CFS_CSA_GAIN       5'h14
`define CFS_HYST_PCT       7'h06

// Register byte offsets
`define CFS_REG_CTRL       4'h0
`define CFS_REG_HS_LIMIT   4'h4
`define CFS_REG_LS_LIMIT   4'h8
`define CFS_REG_CUR_PROG   4'hC
`define CFS_REG_STATUS     5'h10

// Reset values
`define CFS_CTRL_RST       1'h0
`define CFS_HS_LIMIT_RST   12'h0C8
`define CFS_LS_LIMIT_RST   12'h0C8
`define CFS_CUR_PROG_RST   12'h800

// Control and status fields
`define CFS_CTRL_EN_BIT    0
`define CFS_ST_LATCH_BIT   0
`define CFS_ST_COUNT_LSB   1
`define CFS_ST_THERM_BIT   4
`define CFS_ST_ALARM_BIT   5
`define CFS_ST_EXTP_BIT    6
`define CFS_ST_LIMIT_BIT   7
`define CFS_ST_STEP_LSB    8
`define CFS_ST_CHG_BIT     12
`define CFS_ST_PINS_LSB    13

// AXI responses
`define CFS_RESP_OKAY      2'h0
`define CFS_RESP_SLVERR    2'h2

`endif

// [rtl/cfs_hyst_cmp.v]
`timescale 1ns/1ps
// Comparator with separate trip and release levels
module cfs_hyst_cmp #(
   parameter W = 8
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire [W-1:0] value,
   input  wire [W-1:0] trip_level,
   input  wire [W-1:0] release_level,
   output reg          tripped
);

   // Holds state between the two levels so it cannot chatter
   always @(posedge aclk) begin
      if (!aresetn) begin
         tripped <= 1'b0;
      end else if (value > trip_level) begin
         tripped <= 1'b1;
      end else if (value < release_level) begin
         tripped <= 1'b0;
      end
   end

endmodule // cfs_hyst_cmp

// [rtl/cfs_charger_fault.v]
// Notes on behaviour
// - High-side drop is sense-high minus switch node; low-side is switch node minus ground.
// - Short sensing ignored for the blanking time after each switch turn-on; a direct swap from the other gate is sensed in its first cycle.
// - A detected short removes gate drive for the rest of that cycle.
// - On the seventh short detection the charger latches off.
// - Latch cleared only by power-on reset or toggling the charge-permit pin.
// - Converter turns off when die temperature exceeds 155 C.
// - After thermal trip stay off below 135 C, then soft-start if enabled.
// - Each enable ramps current target in eight equal steps of about 1 ms.
// - Alarm pin low while twenty times sense differential exceeds alarm threshold.
// - Alarm comparator hysteresis is 6 percent of the threshold.
// - External-power flag low when adapter sense exceeds 2.4 V.
// - External-power flag also low when current monitor exceeds 250 mV.
// - Power-limit pin low while dynamic power limiting cuts charge current.
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cfs_defs.vh"
module cfs_charger_fault #(
   parameter SS_STEP_CYC = `CFS_SS_STEP_CYC
) (
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Sampled analog levels, mV codes; die temperature in degrees C
   input  wire [11:0] input_sense_high,
   input  wire [11:0] input_sense_low,
   input  wire [11:0] switch_node,
   input  wire [11:0] analog_ground,
   input  wire [11:0] adapter_sense_input,
   input  wire [16:0] alarm_threshold_input,
   input  wire [7:0]  die_temp,
   // Converter and system signals
   input  wire        cycle_start,
   input  wire        pwm_demand,
   input  wire        charge_permit,
   input  wire        other_enable_ok,
   input  wire        dynamic_power_limiting,
   output reg         high_gate,
   output reg         low_gate,
   output reg  [11:0] current_target,
   output reg  [16:0] input_current_monitor,
   output reg         thermal_trip,
   // Open-drain status pins
   input  wire        external_power_flag_in,
   output reg         external_power_flag_out,
   output reg         external_power_flag_oe_n,
   input  wire        input_power_alarm_in,
   output reg         input_power_alarm_out,
   output reg         input_power_alarm_oe_n,
   input  wire        power_limit_active_in,
   output reg         power_limit_active_out,
   output reg         power_limit_active_oe_n
);

   // Software registers
   reg         ctrl_en;
   reg  [11:0] hs_limit;
   reg  [11:0] ls_limit;
   reg  [11:0] cur_prog;
   // Write channel holding
   reg  [3:0]  aw_addr;
   reg         aw_bad;
   reg         aw_got;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_got;
   // Protection state
   reg  [2:0]  sc_count;
   reg         sc_latched;
   reg         cut;
   reg         permit_q;
   reg  [3:0]  blank_cnt;
   reg         gate_q;
   reg         charging;
   reg  [3:0]  ss_step;
   reg  [13:0] ss_cnt;
   reg         extp_cond;
   wire        therm_hot;
   wire        alarm_hot;
   wire        permit_toggle;
   wire        blank_done;
   wire signed [12:0] hs_drop;
   wire signed [12:0] ls_drop;
   wire        hs_over;
   wire        ls_over;
   wire        sc_detect;
   wire        chg_ok;
   wire [11:0] sense_diff;
   wire [16:0] amp_out;
   wire [16:0] alarm_release;
   wire [23:0] hyst_prod;
   wire [15:0] ramp_prod;
   wire [31:0] status_word;

   // Byte-lane merge for the 12-bit writable fields; upper lanes have no bits
   function [11:0] merge;
      input [11:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge = old;
         if (strb[0]) begin
            merge[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge[11:8] = data[11:8];
         end
      end
   endfunction

   // AXI write: address and data accepted in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CFS_RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 4'h0;
         aw_bad        <= 1'b0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         ctrl_en       <= `CFS_CTRL_RST;
         hs_limit      <= `CFS_HS_LIMIT_RST;
         ls_limit      <= `CFS_LS_LIMIT_RST;
         cur_prog      <= `CFS_CUR_PROG_RST;
      end else begin
         s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready  <= !w_got && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr[3:0];
            aw_bad  <= (s_axi_awaddr[31:4] != 28'h0) || (s_axi_awaddr[1:0] != 2'h0);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_got && w_got && !s_axi_bvalid) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_bad ? `CFS_RESP_SLVERR : `CFS_RESP_OKAY;
            if (!aw_bad) begin
               case (aw_addr)
                  `CFS_REG_CTRL: begin
                     if (w_strb[0]) ctrl_en <= w_data[`CFS_CTRL_EN_BIT];
                  end
                  `CFS_REG_HS_LIMIT: hs_limit <= merge(hs_limit, w_data, w_strb);
                  `CFS_REG_LS_LIMIT: ls_limit <= merge(ls_limit, w_data, w_strb);
                  `CFS_REG_CUR_PROG: cur_prog <= merge(cur_prog, w_data, w_strb);
                  default: begin
                     s_axi_bresp <= `CFS_RESP_SLVERR; // Status is read-only
                  end
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status word built from live protection state and pin readback
   assign status_word = {16'h0000,
                         input_power_alarm_in, power_limit_active_in, external_power_flag_in,
                         charging, ss_step, dynamic_power_limiting, extp_cond,
                         alarm_hot, therm_hot, sc_count, sc_latched};

   // AXI read: data one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CFS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CFS_RESP_OKAY;
            case (s_axi_araddr)
               32'h0 | `CFS_REG_CTRL:     s_axi_rdata <= {31'h0, ctrl_en};
               32'h0 | `CFS_REG_HS_LIMIT: s_axi_rdata <= {20'h0, hs_limit};
               32'h0 | `CFS_REG_LS_LIMIT: s_axi_rdata <= {20'h0, ls_limit};
               32'h0 | `CFS_REG_CUR_PROG: s_axi_rdata <= {20'h0, cur_prog};
               32'h0 | `CFS_REG_STATUS:   s_axi_rdata <= status_word;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `CFS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Switch drops, sign kept so reverse drops never trip
   assign hs_drop = $signed({1'b0, input_sense_high}) - $signed({1'b0, switch_node});
   assign ls_drop = $signed({1'b0, switch_node}) - $signed({1'b0, analog_ground});
   assign hs_over = hs_drop > $signed({1'b0, hs_limit});
   assign ls_over = ls_drop > $signed({1'b0, ls_limit});

   // Sensing opens only once the blanking count has run out
   assign blank_done = (blank_cnt >= `CFS_BLANK_CYC);
   assign sc_detect  = !cut && blank_done &&
                       ((high_gate && hs_over) || (low_gate && ls_over));

   // Any edge on the permit pin is a toggle
   assign permit_toggle = (charge_permit != permit_q);

   // Blanking counter restarts at every gate transition
   always @(posedge aclk) begin
      if (!aresetn) begin
         blank_cnt <= 4'h0;
         gate_q    <= 1'b0;
      end else begin
         gate_q <= high_gate;
         if ((high_gate != gate_q) || !(high_gate || low_gate)) begin
            blank_cnt <= 4'h0;
         end else if (!blank_done) begin
            blank_cnt <= blank_cnt + 4'h1;
         end
      end
   end

   // Short counter and latch; a detection in the toggle cycle still counts
   always @(posedge aclk) begin
      if (!aresetn) begin
         sc_count   <= 3'h0;
         sc_latched <= 1'b0;
         permit_q   <= charge_permit; // Idle level, so no false toggle after reset
         cut        <= 1'b0;
      end else begin
         permit_q <= charge_permit;
         // A short on the starting edge still cuts the new cycle; set wins
         if (sc_detect) begin
            cut <= 1'b1;
         end else if (cycle_start) begin
            cut <= 1'b0;
         end
         if (permit_toggle) begin
            sc_count   <= sc_detect ? 3'h1 : 3'h0;
            sc_latched <= 1'b0;
         end else if (sc_detect && !sc_latched) begin
            sc_count <= sc_count + 3'h1;
            if (sc_count == `CFS_SC_LIMIT - 3'h1) begin
               sc_latched <= 1'b1;
            end
         end
      end
   end

   // Thermal comparator trips above 155 C and releases below 135 C
   cfs_hyst_cmp #(
      .W (8)
   ) u_thermal (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .value         (die_temp),
      .trip_level    (`CFS_TEMP_TRIP),
      .release_level (`CFS_TEMP_RELEASE),
      .tripped       (therm_hot)
   );

   // Charger allowed only with every enable condition met
   assign chg_ok = ctrl_en && charge_permit && other_enable_ok && extp_cond &&
                   !therm_hot && !sc_latched;

   // Gate drive, cut for the rest of the cycle after a short
   always @(posedge aclk) begin
      if (!aresetn) begin
         high_gate <= 1'b0;
         low_gate  <= 1'b0;
         charging  <= 1'b0;
      end else begin
         charging  <= chg_ok;
         high_gate <= chg_ok && charging && pwm_demand && !sc_detect &&
                      (!cut || cycle_start);
         low_gate  <= chg_ok && charging && !pwm_demand && !sc_detect &&
                      (!cut || cycle_start);
      end
   end

   // Soft-start ramp; restarts from step one on every enable
   assign ramp_prod = cur_prog * ss_step;
   always @(posedge aclk) begin
      if (!aresetn) begin
         ss_step        <= 4'h0;
         ss_cnt         <= 14'h0000;
         current_target <= 12'h000;
      end else begin
         current_target <= ramp_prod[14:3];
         if (!charging) begin
            ss_step <= 4'h0;
            ss_cnt  <= 14'h0000;
         end else if (ss_step == 4'h0) begin
            ss_step <= 4'h1;
            ss_cnt  <= 14'h0000;
         end else if (ss_step != `CFS_SS_STEPS) begin
            if (ss_cnt == SS_STEP_CYC[13:0] - 14'h0001) begin
               ss_cnt  <= 14'h0000;
               ss_step <= ss_step + 4'h1;
            end else begin
               ss_cnt <= ss_cnt + 14'h0001;
            end
         end
      end
   end

   // Current sense amplifier, negative differential clamps at zero
   assign sense_diff = (input_sense_high > input_sense_low) ?
                       (input_sense_high - input_sense_low) : 12'h000;
   assign amp_out    = sense_diff * `CFS_CSA_GAIN;
   // Release level sits 6 percent below the threshold
   assign hyst_prod     = (alarm_threshold_input * `CFS_HYST_PCT) / 24'h000064;
   assign alarm_release = alarm_threshold_input - hyst_prod[16:0];

   cfs_hyst_cmp #(
      .W (17)
   ) u_alarm (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .value         (amp_out),
      .trip_level    (alarm_threshold_input),
      .release_level (alarm_release),
      .tripped       (alarm_hot)
   );

   // Status pins: output held low, enable low means pulled down
   always @(posedge aclk) begin
      if (!aresetn) begin
         input_current_monitor    <= 17'h00000;
         extp_cond                <= 1'b0;
         thermal_trip             <= 1'b0;
         external_power_flag_out  <= 1'b0;
         external_power_flag_oe_n <= 1'b1;
         input_power_alarm_out    <= 1'b0;
         input_power_alarm_oe_n   <= 1'b1;
         power_limit_active_out   <= 1'b0;
         power_limit_active_oe_n  <= 1'b1;
      end else begin
         input_current_monitor <= amp_out;
         thermal_trip          <= therm_hot;
         extp_cond <= (adapter_sense_input > `CFS_ADAPTER_MV);
         external_power_flag_oe_n <= !((adapter_sense_input > `CFS_ADAPTER_MV) ||
                                       (input_current_monitor > `CFS_CURMON_MV));
         input_power_alarm_oe_n  <= !alarm_hot;
         power_limit_active_oe_n <= !dynamic_power_limiting;
      end
   end

endmodule // cfs_charger_fault

// [testbench/cfs_charger_fault_checker.sv]
`timescale 1ns/1ps
// Watches gate and status pins against the protection and flag inputs
module cfs_charger_fault_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire [11:0] input_sense_high,
   input wire [11:0] switch_node,
   input wire [11:0] analog_ground,
   input wire [11:0] adapter_sense_input,
   input wire [16:0] alarm_threshold_input,
   input wire [7:0]  die_temp,
   input wire        cycle_start,
   input wire        dynamic_power_limiting,
   input wire        high_gate,
   input wire        low_gate,
   input wire [16:0] input_current_monitor,
   input wire        thermal_trip,
   input wire        external_power_flag_oe_n,
   input wire        input_power_alarm_oe_n,
   input wire        power_limit_active_oe_n
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Limits assumed at reset value; the bench restores them before any gate runs
   wire hs_over = {1'b0, input_sense_high} > {1'b0, switch_node} + 13'h00C8;
   wire ls_over = {1'b0, switch_node} > {1'b0, analog_ground} + 13'h00C8;

   property p_hs_cut;
      high_gate [*2] ##1 (high_gate && hs_over && !cycle_start) ##1 !cycle_start
         |-> !high_gate ##1 !high_gate;
   endproperty
   a_hs_cut: assert property (p_hs_cut)
      else $error("high gate kept on after short");
   property p_ls_cut;
      low_gate [*2] ##1 (low_gate && ls_over && !cycle_start) |=> !low_gate;
   endproperty
   a_ls_cut: assert property (p_ls_cut)
      else $error("low gate kept on after short");
   property p_therm_on;
      (die_temp > 8'h9B) [*3] |-> thermal_trip;
   endproperty
   a_therm_on: assert property (p_therm_on)
      else $error("no thermal trip above limit");
   property p_therm_hold;
      (die_temp >= 8'h87) ##1 thermal_trip |=> thermal_trip;
   endproperty
   a_therm_hold: assert property (p_therm_hold)
      else $error("thermal trip released too early");
   property p_therm_gate;
      thermal_trip [*3] |-> !high_gate && !low_gate;
   endproperty
   a_therm_gate: assert property (p_therm_gate)
      else $error("gate on while thermally tripped");
   property p_extp_on;
      (adapter_sense_input > 12'h960) [*2] |-> !external_power_flag_oe_n;
   endproperty
   a_extp_on: assert property (p_extp_on)
      else $error("external power flag not pulled low");
   property p_extp_off;
      (adapter_sense_input <= 12'h960 && input_current_monitor <= 17'h000FA) [*3]
         |-> external_power_flag_oe_n;
   endproperty
   a_extp_off: assert property (p_extp_off)
      else $error("external power flag low without cause");
   property p_alarm_on;
      (input_current_monitor > alarm_threshold_input) [*3] |-> !input_power_alarm_oe_n;
   endproperty
   a_alarm_on: assert property (p_alarm_on)
      else $error("input power alarm not pulled low");
   property p_limit_on;
      dynamic_power_limiting [*2] |-> !power_limit_active_oe_n;
   endproperty
   a_limit_on: assert property (p_limit_on)
      else $error("power limit pin not pulled low");

   c_trip: cover property ($rose(thermal_trip));
   c_cut: cover property (high_gate ##1 (high_gate && hs_over));
   c_alarm: cover property ($fell(input_power_alarm_oe_n));
endmodule // cfs_charger_fault_checker

bind cfs_charger_fault cfs_charger_fault_checker i_chk (.*);

// [testbench/cfs_host_pins.sv]
`timescale 1ns/1ps
// Host side of the three open-drain status pins
module cfs_host_pins (
   input  wire ext_out,
   input  wire ext_oe_n,
   input  wire alarm_out,
   input  wire alarm_oe_n,
   input  wire limit_out,
   input  wire limit_oe_n,
   output wire ext_pin,
   output wire alarm_pin,
   output wire limit_pin
);
   // Pull-ups win whenever the device lets go of a pin
   assign ext_pin   = ext_oe_n ? 1'b1 : ext_out;
   assign alarm_pin = alarm_oe_n ? 1'b1 : alarm_out;
   assign limit_pin = limit_oe_n ? 1'b1 : limit_out;
endmodule // cfs_host_pins

// [testbench/test_cfs_charger_fault.sv]
`timescale 1ns/1ps
// Self-checking bench for the charger protection and status block
module test_cfs_charger_fault;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   reg         s_axi_arvalid, s_axi_rready, cycle_start, pwm_demand, charge_permit;
   reg         other_enable_ok, dynamic_power_limiting;
   reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rd;
   reg  [11:0] input_sense_high, input_sense_low, switch_node, analog_ground;
   reg  [11:0] adapter_sense_input;
   reg  [16:0] alarm_threshold_input;
   reg  [7:0]  die_temp;
   reg  [1:0]  rsp;
   wire [3:0]  s_axi_wstrb = 4'hF;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        high_gate, low_gate, thermal_trip;
   wire [11:0] current_target;
   wire        external_power_flag_in, external_power_flag_out, external_power_flag_oe_n;
   wire        input_power_alarm_in, input_power_alarm_out, input_power_alarm_oe_n;
   wire        power_limit_active_in, power_limit_active_out, power_limit_active_oe_n;
   integer     errors, comparisons, cyc, n, i;

   // Short soft-start steps keep the run brief
   cfs_charger_fault #(.SS_STEP_CYC(16)) i_dut (.*, .input_current_monitor());
   cfs_host_pins i_host (
      .ext_out(external_power_flag_out),
      .ext_oe_n(external_power_flag_oe_n),
      .alarm_out(input_power_alarm_out),
      .alarm_oe_n(input_power_alarm_oe_n),
      .limit_out(power_limit_active_out),
      .limit_oe_n(power_limit_active_oe_n),
      .ext_pin(external_power_flag_in),
      .alarm_pin(input_power_alarm_in),
      .limit_pin(power_limit_active_in)
   );

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task summarize;
      begin
         $display("comparisons %0d errors %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   // Hang guard, well above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         $display("ERROR timeout expected below %0d seen %0d", 5000, cyc);
         summarize;
      end
   end

   task check(input [31:0] seen, input [31:0] exp, input [8*12:1] what);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("ERROR %0s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask

   task cyc_n(input integer k);
      repeat (k) @(posedge aclk);
   endtask

   // Address and data offered together, each dropped once taken
   task axi_wr(input [31:0] a, input [31:0] d, output [1:0] r);
      reg aw_done, w_done;
      begin
         aw_done = 1'b0;
         w_done = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
               aw_done = 1'b1;
               s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
               w_done = 1'b1;
               s_axi_wvalid <= 1'b0;
            end
         end
         do @(posedge aclk); while (!s_axi_bvalid);
         r = s_axi_bresp;
      end
   endtask

   task axi_rd(input [31:0] a, output [31:0] d, output [1:0] r);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge aclk); while (!s_axi_rvalid);
         d = s_axi_rdata;
         r = s_axi_rresp;
      end
   endtask

   task pulse;
      begin
         cycle_start <= 1'b1;
         @(posedge aclk);
         cycle_start <= 1'b0;
      end
   endtask

   // Bounded wait for one of the gates to reach a level
   task wait_gate(input hs, input v);
      begin
         n = 0;
         while (((hs ? high_gate : low_gate) !== v) && n < 40) begin
            @(posedge aclk);
            n = n + 1;
         end
      end
   endtask

   task t_regs;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            axi_rd({i[29:0], 2'b00}, rd, rsp);
            check(rd, i == 0 ? 32'h0 : (i == 3 ? 32'h800 : 32'hC8), "reg_reset");
         end
         axi_rd(32'h20, rd, rsp);
         check(rd, 32'h0, "unmap_data");
         check(rsp, 2'h2, "unmap_resp");
         axi_wr(32'h10, 32'hFFFF, rsp);
         check(rsp, 2'h2, "status_wr");
         axi_wr(32'h4, 32'hFFFF_F123, rsp);
         axi_rd(32'h4, rd, rsp);
         check(rd, 32'h123, "limit_wr");
         axi_wr(32'h4, 32'h0000_00C8, rsp);
      end
   endtask

   task t_ramp;
      begin
         axi_wr(32'h0, 32'h1, rsp);
         check(rsp, 2'h0, "ctrl_wr");
         n = 0;
         while (current_target === 12'h0 && n < 40) begin
            @(posedge aclk);
            n = n + 1;
         end
         check(current_target, 12'h100, "step_one");
         cyc_n(24);
         check(current_target, 12'h200, "step_two");
         cyc_n(120);
         check(current_target, 12'h800, "step_full");
         axi_rd(32'h10, rd, rsp);
         check(rd[12:8], 5'h18, "step_field");
      end
   endtask

   task t_short;
      begin
         switch_node <= 12'hA8C;
         for (i = 1; i <= 7; i = i + 1) begin
            if (i > 1)
               pulse;
            wait_gate(1'b1, 1'b1);
            cyc_n(1);
            check(high_gate, 1'b1, "blank_on");
            wait_gate(1'b1, 1'b0);
            check(high_gate, 1'b0, "hs_cut");
            axi_rd(32'h10, rd, rsp);
            check(rd[3:0], {i[2:0], i == 7}, "sc_status");
         end
         pulse;
         wait_gate(1'b1, 1'b1);
         check(high_gate, 1'b0, "latched");
         switch_node <= 12'hBAE;
         charge_permit <= 1'b0;
         cyc_n(3);
         charge_permit <= 1'b1;
         cyc_n(3);
         axi_rd(32'h10, rd, rsp);
         check(rd[3:0], 4'h0, "sc_clear");
         // Low side: ground pulled away from the switch node
         pulse;
         pwm_demand <= 1'b0;
         wait_gate(1'b0, 1'b1);
         analog_ground <= 12'hA8C;
         wait_gate(1'b0, 1'b0);
         check(low_gate, 1'b0, "ls_cut");
         axi_rd(32'h10, rd, rsp);
         check(rd[3:0], 4'h2, "ls_count");
         analog_ground <= 12'hBAE;
         pwm_demand <= 1'b1;
         pulse;
      end
   endtask

   task t_therm;
      begin
         die_temp <= 8'h9C;
         cyc_n(4);
         check(thermal_trip, 1'b1, "trip");
         cyc_n(2);
         check(high_gate | low_gate, 1'b0, "trip_off");
         die_temp <= 8'h87;
         cyc_n(8);
         check(thermal_trip, 1'b1, "trip_hold");
         die_temp <= 8'h86;
         cyc_n(4);
         check(thermal_trip, 1'b0, "release");
         n = 0;
         while (current_target !== 12'h100 && n < 60) begin
            @(posedge aclk);
            n = n + 1;
         end
         check(current_target, 12'h100, "restart");
      end
   endtask

   // One row: adapter level, sense difference, limiting, pins {ext, alarm, limit}
   task flag_step(input [11:0] a, input [11:0] d, input p, input [2:0] e);
      begin
         adapter_sense_input <= a;
         input_sense_low <= 12'hBB8 - d;
         dynamic_power_limiting <= p;
         cyc_n(4);
         check({external_power_flag_in, input_power_alarm_in, power_limit_active_in}, e,
               "status_pins");
      end
   endtask

   initial begin
      errors = 0;
      comparisons = 0;
      cyc = 0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {cycle_start, dynamic_power_limiting} = 2'h0;
      {pwm_demand, charge_permit, other_enable_ok} = 3'h7;
      input_sense_high = 12'hBB8;
      input_sense_low = 12'hBB8;
      switch_node = 12'hBAE;
      analog_ground = 12'hBAE;
      adapter_sense_input = 12'h9C4;
      alarm_threshold_input = 17'h003E8;
      die_temp = 8'h19;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_ramp;
      t_short;
      t_therm;
      flag_step(12'h9C4, 12'h000, 1'b0, 3'h3);
      flag_step(12'h7D0, 12'h000, 1'b0, 3'h7);
      flag_step(12'h7D0, 12'h00D, 1'b1, 3'h2);
      flag_step(12'h7D0, 12'h00C, 1'b0, 3'h7);
      flag_step(12'h7D0, 12'h033, 1'b0, 3'h1);
      flag_step(12'h7D0, 12'h031, 1'b0, 3'h1);
      flag_step(12'h7D0, 12'h02E, 1'b0, 3'h3);
      summarize;
   end
endmodule // test_cfs_charger_fault
